// [src/pcif_pkg.sv]
// Purpose: Shared constants and types for the pin change interrupt flag block
// Assumes: Four ports (A, B, C, E) of eight pins, 32-bit AXI4-Lite register access
// Notes:   Register offsets are word indices; byte address is four times the index
package pcif_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int NPORTS = 4;
  localparam int PORT_W = 8;
  localparam int NPINS  = NPORTS * PORT_W;
  localparam int IDX_W  = 14;
  localparam int ADDR_W = 16;

  // Implemented pins per port, index 0..3 = A, B, C, E
  localparam logic [NPORTS-1:0][PORT_W-1:0] PORT_IMPL = {8'h08, 8'hFF, 8'hFF, 8'hFF};
  // External reset pin: port E bit 3
  localparam int EXT_RST_BIT = 3 * PORT_W + 3;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [NPORTS-1:0][IDX_W-1:0] RISE_IDX = {14'h1EB9, 14'h1EA5, 14'h1E9B, 14'h1E91};
  localparam logic [NPORTS-1:0][IDX_W-1:0] FALL_IDX = {14'h1EBA, 14'h1EA6, 14'h1E9C, 14'h1E92};
  localparam logic [NPORTS-1:0][IDX_W-1:0] FLAG_IDX = {14'h1EBB, 14'h1EA7, 14'h1E9D, 14'h1E93};
  localparam logic [IDX_W-1:0] CTRL_IDX   = 14'h1EC0;
  localparam logic [IDX_W-1:0] STATUS_IDX = 14'h1EC1;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CTRL_IRQ_EN_BIT = 0;
  localparam int CTRL_EXTRST_BIT = 1;
  localparam int CTRL_LVP_BIT    = 2;
  localparam int STATUS_SUM_BIT  = 0;
  localparam logic [PORT_W-1:0] ENABLE_RST = 8'h00;
  localparam logic [PORT_W-1:0] FLAG_RST   = 8'h00;
  localparam logic [2:0]        CTRL_RST   = 3'h0;

  // Synchroniser fill time before edges are trusted
  localparam logic [1:0] PRIME_CYCLES = 2'h3;

  // ****************************************
  // AXI responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Per-port edge enables
  typedef struct packed {
    logic [PORT_W-1:0] rise;
    logic [PORT_W-1:0] fall;
  } pcif_port_cfg_t;

  // Global control bits
  typedef struct packed {
    logic lvp_en;
    logic ext_rst_en;
    logic irq_en;
  } pcif_ctrl_t;

endpackage : pcif_pkg

// [src/pcif_top.sv]
// Purpose: Per-pin edge detection, change flags, summary request and wake for four ports
// Assumes: Pins are asynchronous; registers reached over AXI4-Lite, one access of each kind
// Notes:   Flags clear on written zeros; a same-cycle edge keeps its flag set
//
// What this block does
// - An edge of an enabled polarity on a pin sets that pin's change flag.
// - The interrupt request to the core is raised only while the change interrupt enable is set.
// - The summary request is the OR of every per-pin change flag of every port.
// - The summary is read-only and falls only once every flag has been cleared.
// - Writing zero to a flag bit clears it; writing one leaves it alone.
// - An edge detected in the cycle of a clearing write leaves its flag set.
// - A detected enabled edge wakes the device when the change interrupt enable is set.
// - An edge seen during sleep is in its flag before the core runs its first instruction.
// - Flag n is set by a rising edge when rise enable n is 1, by a falling edge when fall enable n is 1.
// - Fall enable n at 1 enables falling-edge detection on pin n, at 0 suppresses it.
// - Rise enable n at 1 enables rising-edge detection on pin n, at 0 suppresses it.
// - With external reset pin or low voltage programming enabled, that pin's flag never sets.
// - Both enables set on one pin detect edges of either polarity.
// - With the change interrupt enable clear, detection and flags continue.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps

module pcif_top (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [pcif_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [pcif_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic [pcif_pkg::NPINS-1:0]    pin_in,
  output logic                               change_irq_summary,
  output logic                               change_irq,
  output logic                               wake_req
);

  // ****************************************
  // Write channel capture
  // ****************************************
  logic                             aw_full_reg;
  logic [pcif_pkg::IDX_W-1:0]       aw_idx_reg;
  logic                             w_full_reg;
  logic [7:0]                       w_data_reg;
  logic                             w_strb_reg;
  logic                             bvalid_reg;
  logic [1:0]                       bresp_reg;
  logic                             wr_en;
  logic                             wr_hit;

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_en         = aw_full_reg && w_full_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_idx_reg  <= '0;
    end else if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
      aw_idx_reg  <= s_axi_awaddr[pcif_pkg::ADDR_W-1:2];
    end else if (wr_en) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
    end else if (s_axi_wvalid && !w_full_reg) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata[7:0];
      w_strb_reg <= s_axi_wstrb[0];
    end else if (wr_en) begin
      w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= pcif_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? pcif_pkg::RESP_OKAY : pcif_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  pcif_pkg::pcif_ctrl_t ctrl_reg;
  logic                 wr_ctrl;

  assign wr_ctrl = wr_en && w_strb_reg && (aw_idx_reg == pcif_pkg::CTRL_IDX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= pcif_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg.irq_en     <= w_data_reg[pcif_pkg::CTRL_IRQ_EN_BIT];
      ctrl_reg.ext_rst_en <= w_data_reg[pcif_pkg::CTRL_EXTRST_BIT];
      ctrl_reg.lvp_en     <= w_data_reg[pcif_pkg::CTRL_LVP_BIT];
    end
  end

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [pcif_pkg::NPINS-1:0] sync1_reg;
  logic [pcif_pkg::NPINS-1:0] sync2_reg;
  logic [pcif_pkg::NPINS-1:0] sync3_reg;
  logic [pcif_pkg::NPINS-1:0] level_reg;
  logic [1:0]                 prime_reg;
  logic                       primed;
  logic [pcif_pkg::NPINS-1:0] stable;
  logic [pcif_pkg::NPINS-1:0] rise_edge;
  logic [pcif_pkg::NPINS-1:0] fall_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Edges are ignored until the chain holds real pin samples
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prime_reg <= 2'h0;
    end else if (!primed) begin
      prime_reg <= prime_reg + 2'h1;
    end
  end

  assign primed    = (prime_reg == pcif_pkg::PRIME_CYCLES);
  assign stable    = ~(sync2_reg ^ sync3_reg);
  assign rise_edge = {pcif_pkg::NPINS{primed}} & stable & sync3_reg & ~level_reg;
  assign fall_edge = {pcif_pkg::NPINS{primed}} & stable & ~sync3_reg & level_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_reg <= '0;
    end else if (!primed) begin
      // Baseline from the stage ahead, so the first trusted compare sees no false edge
      level_reg <= sync2_reg;
    end else begin
      level_reg <= (level_reg & ~stable) | (sync3_reg & stable);
    end
  end

  // ****************************************
  // Per-port enables and flags
  // ****************************************
  pcif_pkg::pcif_port_cfg_t [pcif_pkg::NPORTS-1:0]    cfg_reg;
  logic [pcif_pkg::NPORTS-1:0][pcif_pkg::PORT_W-1:0]  flag_reg;
  logic [pcif_pkg::NPINS-1:0]                         set_vec;
  logic [pcif_pkg::NPINS-1:0]                         pin_avail;
  logic [pcif_pkg::NPORTS-1:0]                        port_hit;

  // The external reset pin loses its change detection when it acts as reset
  always_comb begin
    pin_avail = pcif_pkg::PORT_IMPL;
    if (ctrl_reg.ext_rst_en || ctrl_reg.lvp_en) begin
      pin_avail[pcif_pkg::EXT_RST_BIT] = 1'b0;
    end
  end

  for (genvar p = 0; p < pcif_pkg::NPORTS; p++) begin : g_port
    logic [pcif_pkg::PORT_W-1:0] set_p;
    logic                        wr_rise;
    logic                        wr_fall;
    logic                        wr_flag;

    assign wr_rise = wr_en && w_strb_reg && (aw_idx_reg == pcif_pkg::RISE_IDX[p]);
    assign wr_fall = wr_en && w_strb_reg && (aw_idx_reg == pcif_pkg::FALL_IDX[p]);
    assign wr_flag = wr_en && w_strb_reg && (aw_idx_reg == pcif_pkg::FLAG_IDX[p]);
    assign port_hit[p] = (aw_idx_reg == pcif_pkg::RISE_IDX[p])
                      || (aw_idx_reg == pcif_pkg::FALL_IDX[p])
                      || (aw_idx_reg == pcif_pkg::FLAG_IDX[p]);

    // Either polarity may be enabled alone or together
    assign set_p = ((rise_edge[p*8 +: 8] & cfg_reg[p].rise)
                 |  (fall_edge[p*8 +: 8] & cfg_reg[p].fall))
                 & pin_avail[p*8 +: 8];
    assign set_vec[p*8 +: 8] = set_p;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_reg[p].rise <= pcif_pkg::ENABLE_RST;
      end else if (wr_rise) begin
        cfg_reg[p].rise <= w_data_reg & pcif_pkg::PORT_IMPL[p];
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_reg[p].fall <= pcif_pkg::ENABLE_RST;
      end else if (wr_fall) begin
        cfg_reg[p].fall <= w_data_reg & pcif_pkg::PORT_IMPL[p];
      end
    end

    // Zeros written clear, ones keep; a new edge overrides the clear
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag_reg[p] <= pcif_pkg::FLAG_RST;
      end else if (wr_flag) begin
        flag_reg[p] <= (flag_reg[p] & w_data_reg) | set_p;
      end else begin
        flag_reg[p] <= flag_reg[p] | set_p;
      end
    end

    flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_flag && (w_data_reg == 8'h00) && (set_p == 8'h00) |=> (flag_reg[p] == 8'h00))
      else $error("written zero did not clear the flags");

    impl_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ((flag_reg[p] | cfg_reg[p].rise | cfg_reg[p].fall) & ~pcif_pkg::PORT_IMPL[p]) == 8'h00)
      else $error("unimplemented bit became set");
  end

  assign wr_hit = (|port_hit) || (aw_idx_reg == pcif_pkg::CTRL_IDX)
               || (aw_idx_reg == pcif_pkg::STATUS_IDX);

  // ****************************************
  // Summary, interrupt and wake
  // ****************************************
  assign change_irq_summary = |flag_reg;
  assign change_irq         = change_irq_summary && ctrl_reg.irq_en;
  // Flag is already written when wake rises, so the core reads it at once
  assign wake_req           = change_irq;

  // ****************************************
  // Read channel
  // ****************************************
  logic                       rvalid_reg;
  logic [31:0]                rdata_reg;
  logic [1:0]                 rresp_reg;
  logic [pcif_pkg::IDX_W-1:0] ar_idx;
  logic [7:0]                 rd_byte;
  logic                       rd_hit;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign ar_idx        = s_axi_araddr[pcif_pkg::ADDR_W-1:2];

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b0;
    for (int p = 0; p < pcif_pkg::NPORTS; p++) begin
      if (ar_idx == pcif_pkg::RISE_IDX[p]) begin
        rd_byte = cfg_reg[p].rise;
        rd_hit  = 1'b1;
      end
      if (ar_idx == pcif_pkg::FALL_IDX[p]) begin
        rd_byte = cfg_reg[p].fall;
        rd_hit  = 1'b1;
      end
      if (ar_idx == pcif_pkg::FLAG_IDX[p]) begin
        rd_byte = flag_reg[p];
        rd_hit  = 1'b1;
      end
    end
    if (ar_idx == pcif_pkg::CTRL_IDX) begin
      rd_byte = {5'h00, ctrl_reg};
      rd_hit  = 1'b1;
    end
    if (ar_idx == pcif_pkg::STATUS_IDX) begin
      rd_byte = {7'h00, change_irq_summary};
      rd_hit  = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= pcif_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rd_byte};
      rresp_reg  <= rd_hit ? pcif_pkg::RESP_OKAY : pcif_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> ((flag_reg & $past(set_vec)) == $past(set_vec)))
    else $error("detected edge not held in its flag");

  flag_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> ((flag_reg & ~$past(flag_reg) & ~$past(set_vec)) == '0))
    else $error("flag set without an enabled edge");

  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_reg.irq_en |-> !change_irq)
    else $error("interrupt raised while disabled");

  summary_or_a: assert property (@(posedge aclk) disable iff (!aresetn)
    change_irq_summary == (flag_reg != '0))
    else $error("summary differs from OR of flags");

  summary_fall_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(change_irq_summary) |-> (flag_reg == '0))
    else $error("summary fell with a flag still set");

  wake_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (|set_vec) && ctrl_reg.irq_en |=> wake_req && change_irq_summary)
    else $error("enabled edge did not wake");

  reset_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_reg.ext_rst_en || ctrl_reg.lvp_en) |-> !set_vec[pcif_pkg::EXT_RST_BIT])
    else $error("reset pin change detected while unavailable");

  one_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((rise_edge | fall_edge) & $past(rise_edge | fall_edge)) == '0)
    else $error("edge gave more than one set pulse");

  reset_zero_a: assert property (@(posedge aclk)
    !aresetn |=> (flag_reg == '0) && !ctrl_reg.irq_en)
    else $error("flags not zero after reset");

endmodule : pcif_top

// [sim/pcif_pin_model.sv]
// Purpose: Model of the external circuits that drive the port pins
// Assumes: Pin levels move with no relation to the block clock
// Notes:   SKEW_NS sets how long after a request the pin really moves
`timescale 1ns/1ps

module pcif_pin_model #(
  parameter real SKEW_NS = 1.7
) (
  input  wire logic [pcif_pkg::NPINS-1:0] pin_level,
  output wire logic [pcif_pkg::NPINS-1:0] pin_in
);
  // Off-grid delay keeps pin changes away from the sampling edge
  assign #(SKEW_NS) pin_in = pin_level;
endmodule : pcif_pin_model

// [sim/tb_pcif_top.sv]
// Purpose: Self-checking bench for the pin change flag block
// Assumes: AXI4-Lite register access, pins driven through the pin model
// Notes:   Register byte address is four times the index
`timescale 1ns/1ps

module tb_pcif_top;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [15:0] s_axi_awaddr = 16'h0;
  logic [15:0] s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        change_irq_summary, change_irq, wake_req;
  logic [31:0] pin_level = 32'h0;
  logic [31:0] pin_in;
  logic        seen_sum = 1'h0;
  int          miscompares = 0;
  int          cmp_count = 0;

  always #2.5 aclk = ~aclk;

  pcif_pin_model pcif_pin_model_inst (.pin_level, .pin_in);

  pcif_top pcif_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .change_irq_summary,
    .change_irq, .wake_req
  );

  always @(posedge aclk) if (change_irq_summary === 1'h1) seen_sum = 1'h1;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic results();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'h1) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'h1) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    // Raised only once both the address and the data handshakes have completed
    s_axi_bready <= 1'h1;
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    s_axi_bready <= 1'h0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask : wr

  task automatic rd(input logic [13:0] idx, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic rdchk(input logic [13:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    chk($sformatf("reg %h", idx), {24'h0, exp}, d);
    chk("rresp", 32'(pcif_pkg::RESP_OKAY), 32'(r));
  endtask : rdchk

  // Pin change is in its flag four edges after it appears
  task automatic pin(input int n, input logic v);
    pin_level[n] <= v;
    repeat (8) @(posedge aclk);
  endtask : pin

  task automatic edge_case(input int n, input logic re, input logic fe);
    int          p;
    logic [7:0]  b;
    p = n / 8;
    b = 8'h01 << (n % 8);
    wr(pcif_pkg::RISE_IDX[p], re ? b : 8'h00, pcif_pkg::RESP_OKAY);
    wr(pcif_pkg::FALL_IDX[p], fe ? b : 8'h00, pcif_pkg::RESP_OKAY);
    pin(n, 1'h1);
    rdchk(pcif_pkg::FLAG_IDX[p], re ? b : 8'h00);
    chk("summary", 32'(re), 32'(change_irq_summary));
    chk("irq", 32'h0, 32'(change_irq));
    wr(pcif_pkg::FLAG_IDX[p], ~b, pcif_pkg::RESP_OKAY);
    rdchk(pcif_pkg::FLAG_IDX[p], 8'h00);
    chk("summary", 32'h0, 32'(change_irq_summary));
    pin(n, 1'h0);
    rdchk(pcif_pkg::FLAG_IDX[p], fe ? b : 8'h00);
    wr(pcif_pkg::FLAG_IDX[p], 8'h00, pcif_pkg::RESP_OKAY);
    wr(pcif_pkg::RISE_IDX[p], 8'h00, pcif_pkg::RESP_OKAY);
    wr(pcif_pkg::FALL_IDX[p], 8'h00, pcif_pkg::RESP_OKAY);
  endtask : edge_case

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [2:0]  ctl [3] = '{3'h3, 3'h5, 3'h1};
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    for (int p = 0; p < pcif_pkg::NPORTS; p++) begin
      rdchk(pcif_pkg::RISE_IDX[p], 8'h00);
      rdchk(pcif_pkg::FALL_IDX[p], 8'h00);
      rdchk(pcif_pkg::FLAG_IDX[p], 8'h00);
      wr(pcif_pkg::FALL_IDX[p], 8'hFF, pcif_pkg::RESP_OKAY);
      rdchk(pcif_pkg::FALL_IDX[p], pcif_pkg::PORT_IMPL[p]);
      wr(pcif_pkg::FALL_IDX[p], 8'h00, pcif_pkg::RESP_OKAY);
      wr(pcif_pkg::FLAG_IDX[p], 8'hFF, pcif_pkg::RESP_OKAY);
      rdchk(pcif_pkg::FLAG_IDX[p], 8'h00);
    end
    rdchk(pcif_pkg::CTRL_IDX, 8'h00);
    rd(14'h1E94, d, r);
    chk("rresp unmapped", 32'(pcif_pkg::RESP_SLVERR), 32'(r));
    wr(14'h1E94, 8'hFF, pcif_pkg::RESP_SLVERR);
    edge_case(0, 1'h1, 1'h0);
    edge_case(15, 1'h0, 1'h1);
    edge_case(18, 1'h1, 1'h1);
    edge_case(27, 1'h1, 1'h1);
    // Summary held by a second port's flag
    wr(pcif_pkg::RISE_IDX[0], 8'h01, pcif_pkg::RESP_OKAY);
    wr(pcif_pkg::RISE_IDX[2], 8'h04, pcif_pkg::RESP_OKAY);
    // Write with its byte strobe low leaves the register alone
    s_axi_wstrb <= 4'h0;
    wr(pcif_pkg::RISE_IDX[0], 8'hFF, pcif_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rdchk(pcif_pkg::RISE_IDX[0], 8'h01);
    pin(0, 1'h1);
    pin(18, 1'h1);
    wr(pcif_pkg::FLAG_IDX[0], 8'hFE, pcif_pkg::RESP_OKAY);
    wr(pcif_pkg::STATUS_IDX, 8'h00, pcif_pkg::RESP_OKAY);
    rdchk(pcif_pkg::STATUS_IDX, 8'h01);
    wr(pcif_pkg::FLAG_IDX[2], 8'hFB, pcif_pkg::RESP_OKAY);
    rdchk(pcif_pkg::STATUS_IDX, 8'h00);
    // Wake with the flag already in place
    wr(pcif_pkg::CTRL_IDX, 8'h01, pcif_pkg::RESP_OKAY);
    pin_level[0] <= 1'h0;
    repeat (8) @(posedge aclk);
    wr(pcif_pkg::FALL_IDX[0], 8'h01, pcif_pkg::RESP_OKAY);
    pin_level[0] <= 1'h1;
    for (int i = 0; i < 20 && wake_req !== 1'h1; i++) @(posedge aclk);
    chk("wake", 32'h1, 32'(wake_req));
    chk("summary at wake", 32'h1, 32'(change_irq_summary));
    chk("irq", 32'h1, 32'(change_irq));
    wr(pcif_pkg::FLAG_IDX[0], 8'h00, pcif_pkg::RESP_OKAY);
    chk("irq", 32'h0, 32'(change_irq));
    // External reset pin: blocked by either enable
    wr(pcif_pkg::RISE_IDX[3], 8'h08, pcif_pkg::RESP_OKAY);
    foreach (ctl[k]) begin
      wr(pcif_pkg::CTRL_IDX, {5'h0, ctl[k]}, pcif_pkg::RESP_OKAY);
      pin(27, 1'h1);
      rdchk(pcif_pkg::FLAG_IDX[3], (ctl[k] == 3'h1) ? 8'h08 : 8'h00);
      pin(27, 1'h0);
    end
    wr(pcif_pkg::FLAG_IDX[3], 8'h00, pcif_pkg::RESP_OKAY);
    // Edge against clearing write at every offset: no edge may vanish
    wr(pcif_pkg::RISE_IDX[0], 8'h02, pcif_pkg::RESP_OKAY);
    wr(pcif_pkg::FALL_IDX[0], 8'h02, pcif_pkg::RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      seen_sum = 1'h0;
      pin_level[1] <= ~pin_level[1];
      repeat (k) @(posedge aclk);
      wr(pcif_pkg::FLAG_IDX[0], 8'h00, pcif_pkg::RESP_OKAY);
      repeat (8) @(posedge aclk);
      chk("edge kept", 32'h1, 32'(seen_sum));
      wr(pcif_pkg::FLAG_IDX[0], 8'h00, pcif_pkg::RESP_OKAY);
    end
    // Mid-run reset with pin 0 held high: no false edge once detection resumes
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    wr(pcif_pkg::RISE_IDX[0], 8'h01, pcif_pkg::RESP_OKAY);
    repeat (8) @(posedge aclk);
    rdchk(pcif_pkg::FLAG_IDX[0], 8'h00);
    chk("summary after reset", 32'h0, 32'(change_irq_summary));
    results();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    results();
  end
endmodule : tb_pcif_top
